/* frer_pkg.sv */
// shared constants and types for the frame replication and elimination unit
package frer_pkg;
  // sequence space and counters
  localparam int SEQ_W          = 16;
  localparam int CNT_W          = 32;
  localparam int MAX_STREAMS    = 8;
  localparam int MAX_PORTS      = 8;
  // history window
  localparam int HIST_MIN       = 2;
  localparam int HIST_MAX       = 32;
  localparam logic [5:0] HIST_DEF = 6'h02;
  // recovery reset timeout, milliseconds
  localparam int TMO_MIN        = 1;
  localparam int TMO_MAX        = 4095;
  localparam logic [11:0] TMO_DEF = 12'h3e8;
  // latent error detection
  localparam int ERR_DIFF_MAX   = 10000000;
  localparam logic [23:0] ERR_DIFF_DEF = 24'h000064;
  localparam int LAT_MIN_MS     = 1000;
  localparam int LAT_MAX_MS     = 86400000;
  localparam logic [26:0] LAT_TEST_DEF  = 27'h00007d0;
  localparam logic [26:0] LAT_RESET_DEF = 27'h0007530;
  localparam int PATHS_MIN      = 2;
  localparam int PATHS_MAX      = 8;
  localparam logic [3:0] PATHS_DEF = 4'h2;
  // timebase
  localparam int CLK_PERIOD_NS  = 10;
  localparam int MS_NS          = 1000000;
  localparam int CYC_PER_MS     = MS_NS / CLK_PERIOD_NS;

  typedef enum logic {MODE_GEN, MODE_RCVY} mode_t;
  typedef enum logic {ALG_VECTOR, ALG_MATCH} alg_t;
  localparam mode_t MODE_DEF = MODE_GEN;
  localparam alg_t  ALG_DEF  = ALG_VECTOR;
endpackage

/* frer_rcvy_fn.sv */
// one sequence recovery function: match or vector algorithm with statistics
`timescale 1ns/1ps
module frer_rcvy_fn #(
  parameter int CNT_W = frer_pkg::CNT_W
) (
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset,
  // configuration
  input  wire frer_pkg::alg_t    i_alg,
  input  wire logic [5:0]        i_hist_len,
  input  wire logic [11:0]       i_timeout_ms,
  input  wire logic              i_accept_untagged,
  // control
  input  wire logic              i_ms_tick,
  input  wire logic              i_fn_reset,
  input  wire logic              i_stat_clear,
  // frame
  input  wire logic              i_frame_valid,
  input  wire logic              i_tagged,
  input  wire logic [15:0]       i_seq,
  output logic                   o_pass,
  // statistics
  output logic [CNT_W-1:0]       o_passed,
  output logic [CNT_W-1:0]       o_discarded,
  output logic [CNT_W-1:0]       o_out_of_order,
  output logic [CNT_W-1:0]       o_rogue,
  output logic [CNT_W-1:0]       o_lost,
  output logic [CNT_W-1:0]       o_tagless,
  output logic [CNT_W-1:0]       o_resets
);
  logic [15:0] last_reg;
  logic [31:0] hist_reg;
  logic        take_any_reg;
  logic [11:0] timer_reg;

  function automatic logic [CNT_W-1:0] sat_add(input logic [CNT_W-1:0] c, input logic clr,
                                               input logic [5:0] n);
    logic [CNT_W:0] s;
    s = {1'b0, (clr ? '0 : c)} + {{(CNT_W-5){1'b0}}, n};
    sat_add = s[CNT_W] ? '1 : s[CNT_W-1:0];
  endfunction

  // zeros leaving the window when it advances by d
  function automatic logic [5:0] lost_count(input logic [31:0] h, input logic [5:0] len,
                                            input logic [5:0] d);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (i < len && (i + d) >= len && !h[i]) begin
        n = n + 6'h01;
      end
    end
    lost_count = n;
  endfunction

  // differences taken in the 16-bit circular space
  wire [15:0] delta     = i_seq - last_reg;
  wire [15:0] back      = last_reg - i_seq;
  wire        ahead     = !delta[15] && (delta != 16'h0000) && (delta <= {10'h000, i_hist_len});
  wire        behind    = delta[15] && (back < {10'h000, i_hist_len});
  wire        seen      = behind && hist_reg[back[4:0]];
  wire [31:0] len_mask  = (32'h1 << i_hist_len) - 32'h1;
  wire        is_match  = (i_alg == frer_pkg::ALG_MATCH);
  wire        tag_frame = i_frame_valid && i_tagged;
  wire        acc_match = take_any_reg || (delta != 16'h0000);
  // vector drops outside window or already seen
  wire        acc_vec   = take_any_reg || ahead || (behind && !seen);
  wire        accept    = tag_frame && (is_match ? acc_match : acc_vec);
  // match out-of-order unless exactly one ahead
  wire        ooo       = accept && !take_any_reg &&
                          (is_match ? (delta != 16'h0001) : behind);
  wire        rogue     = tag_frame && !is_match && !take_any_reg && !ahead && !behind &&
                          (delta != 16'h0000);
  wire        untag     = i_frame_valid && !i_tagged;
  // untagged pass only when option set
  wire        pass_un   = untag && i_accept_untagged;
  wire        expire    = i_ms_tick && !take_any_reg && ((timer_reg + 12'h001) >= i_timeout_ms);
  wire [5:0]  lost_n    = (accept && !is_match && !take_any_reg && ahead) ?
                          lost_count(hist_reg, i_hist_len, delta[5:0]) : 6'h00;

  assign o_pass = accept || pass_un;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      last_reg     <= 16'h0000;
      hist_reg     <= 32'h00000000;
      take_any_reg <= 1'b1;
      timer_reg    <= 12'h000;
    end else if (i_fn_reset) begin
      hist_reg     <= 32'h00000000;
      take_any_reg <= 1'b1;
      timer_reg    <= 12'h000;
    end else if (accept) begin
      last_reg     <= (take_any_reg || is_match || ahead) ? i_seq : last_reg;
      timer_reg    <= 12'h000;
      take_any_reg <= 1'b0;
      if (take_any_reg) begin
        hist_reg <= 32'h00000001;
      end else if (ahead) begin
        hist_reg <= ((hist_reg << delta[5:0]) | 32'h00000001) & len_mask;
      end else if (behind) begin
        hist_reg <= hist_reg | (32'h1 << back[4:0]);
      end
    end else if (expire) begin
      // expiry opens acceptance of any number
      take_any_reg <= 1'b1;
      timer_reg    <= 12'h000;
    end else if (i_ms_tick && !take_any_reg) begin
      timer_reg <= timer_reg + 12'h001;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_passed       <= '0;
      o_discarded    <= '0;
      o_out_of_order <= '0;
      o_rogue        <= '0;
      o_lost         <= '0;
      o_tagless      <= '0;
      o_resets       <= '0;
    end else begin
      o_passed       <= sat_add(o_passed, i_stat_clear, {5'h00, o_pass});
      o_discarded    <= sat_add(o_discarded, i_stat_clear, {5'h00, i_frame_valid && !o_pass});
      o_out_of_order <= sat_add(o_out_of_order, i_stat_clear, {5'h00, ooo});
      o_rogue        <= sat_add(o_rogue, i_stat_clear, {5'h00, rogue});
      // lost numbers added as window moves
      o_lost         <= sat_add(o_lost, i_stat_clear, lost_n);
      o_tagless      <= sat_add(o_tagless, i_stat_clear, {5'h00, untag});
      o_resets       <= sat_add(o_resets, i_stat_clear, {5'h00, expire && !i_fn_reset});
    end
  end

  AST_MATCH_REPEAT: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    tag_frame && is_match && !take_any_reg && (i_seq == last_reg) |-> !o_pass)
    else $error("match passed a repeated number");
  AST_EXPIRED_ACCEPTS: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    tag_frame && take_any_reg |-> o_pass)
    else $error("frame refused after timer expiry");
  AST_TIMER_RESTART: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    accept && !i_fn_reset |=> (timer_reg == 12'h000) && !take_any_reg)
    else $error("timer not restarted by accepted frame");
  AST_ROGUE_COUNTS: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    rogue && !i_stat_clear && !(&o_rogue) && !(&o_discarded) |=>
      (o_rogue == $past(o_rogue) + 1) && (o_discarded == $past(o_discarded) + 1))
    else $error("rogue frame not counted in both counters");
  AST_SATURATE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (&o_passed) && !i_stat_clear |=> (&o_passed))
    else $error("passed counter wrapped");
endmodule

/* frer_sequence_recovery.sv */
// frame replication and elimination instance: generator or recovery with latent detection
// How it works
// - generator or recovery, generator after reset
// - match drops repeat of last number
// - match timer expiry accepts anything; restarts
// - match counts expiries, pass, drop, order
// - vector drops outside window or seen
// - vector timer expiry accepts next frame
// - older unseen vector frames pass, out-of-order
// - rogue frames counted rogue and discarded
// - lost count grows as window advances
// - untagged counted; passed only with option
// - same algorithm everywhere; vector default
// - history 2-32; timeout 1-4095 ms, 1000
// - sequence numbers are 16-bit circular
// - compound per port; optional individual ahead
// - terminate strips tag on egress
// - untagged passed frames leave with zero
// - reset period stores latent baseline
// - test period compares; sticky error flag
// - error difference 0-10000000, default 100
// - latent periods 1000-86400000 ms; 2000, 30000
// - paths 2-8, default 2
// - up to 8 streams, ports; generator one
`timescale 1ns/1ps
module frer_sequence_recovery #(
  parameter int CYC_PER_MS = frer_pkg::CYC_PER_MS,
  parameter int NS         = frer_pkg::MAX_STREAMS,
  parameter int NP         = frer_pkg::MAX_PORTS,
  parameter int CNT_W      = frer_pkg::CNT_W
) (
  // clock and reset
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_reset,
  // configuration, captured on i_cfg_write
  input  wire logic                      i_cfg_write,
  input  wire frer_pkg::mode_t           i_cfg_mode,
  input  wire logic                      i_cfg_enable,
  input  wire frer_pkg::alg_t            i_cfg_alg,
  input  wire logic [5:0]                i_cfg_hist_len,
  input  wire logic [11:0]               i_cfg_timeout_ms,
  input  wire logic                      i_cfg_accept_untagged_option,
  input  wire logic                      i_cfg_individual,
  input  wire logic                      i_cfg_terminate,
  input  wire logic                      i_cfg_lat_enable,
  input  wire logic [23:0]               i_cfg_err_diff,
  input  wire logic [26:0]               i_cfg_lat_period_ms,
  input  wire logic [3:0]                i_cfg_lat_paths,
  input  wire logic [26:0]               i_cfg_lat_reset_ms,
  input  wire logic [NS-1:0]             i_cfg_stream_map,
  input  wire logic [NP-1:0]             i_cfg_port_map,
  // control strobes
  input  wire logic                      i_fn_reset,
  input  wire logic                      i_stat_clear,
  input  wire logic                      i_latent_clear,
  // ingress member frames
  input  wire logic                      i_in_valid,
  input  wire logic [$clog2(NS)-1:0]     i_in_stream,
  input  wire logic                      i_in_tagged,
  input  wire logic [15:0]               i_in_seq,
  input  wire logic [NP-1:0]             i_in_port_mask,
  // egress frames
  output logic [NP-1:0]                  o_eg_valid,
  output logic [NP-1:0]                  o_eg_tagged,
  output logic [NP-1:0][15:0]            o_eg_seq,
  // status
  output frer_pkg::mode_t                o_mode,
  output logic                           o_latent_error,
  output logic signed [63:0]             o_latent_baseline_difference,
  output logic [NP-1:0][CNT_W-1:0]       o_cnt_passed,
  output logic [NP-1:0][CNT_W-1:0]       o_cnt_discarded,
  output logic [NP-1:0][CNT_W-1:0]       o_cnt_out_of_order,
  output logic [NP-1:0][CNT_W-1:0]       o_cnt_rogue,
  output logic [NP-1:0][CNT_W-1:0]       o_cnt_lost,
  output logic [NP-1:0][CNT_W-1:0]       o_cnt_tagless,
  output logic [NP-1:0][CNT_W-1:0]       o_cnt_resets
);
  localparam int MS_W  = $clog2(CYC_PER_MS);
  localparam int SUM_W = CNT_W + $clog2(NP) + 1;

  function automatic logic [31:0] clamp32(input logic [31:0] v, input int lo, input int hi);
    clamp32 = (v < 32'(lo)) ? 32'(lo) : ((v > 32'(hi)) ? 32'(hi) : v);
  endfunction

  // configuration registers
  frer_pkg::alg_t  alg_reg;
  logic            enable_reg;
  logic [5:0]      hist_len_reg;
  logic [11:0]     timeout_reg;
  logic            untag_reg;
  logic            individual_reg;
  logic            terminate_reg;
  logic            lat_enable_reg;
  logic [23:0]     err_diff_reg;
  logic [26:0]     lat_period_reg;
  logic [3:0]      paths_reg;
  logic [26:0]     lat_reset_reg;
  logic [NS-1:0]   stream_map_reg;
  logic [NP-1:0]   port_map_reg;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_mode         <= frer_pkg::MODE_DEF;
      alg_reg        <= frer_pkg::ALG_DEF;
      enable_reg     <= 1'b0;
      hist_len_reg   <= frer_pkg::HIST_DEF;
      timeout_reg    <= frer_pkg::TMO_DEF;
      untag_reg      <= 1'b0;
      individual_reg <= 1'b0;
      terminate_reg  <= 1'b0;
      lat_enable_reg <= 1'b0;
      err_diff_reg   <= frer_pkg::ERR_DIFF_DEF;
      lat_period_reg <= frer_pkg::LAT_TEST_DEF;
      paths_reg      <= frer_pkg::PATHS_DEF;
      lat_reset_reg  <= frer_pkg::LAT_RESET_DEF;
      stream_map_reg <= '0;
      port_map_reg   <= '0;
    end else if (i_cfg_write) begin
      o_mode         <= i_cfg_mode;
      alg_reg        <= i_cfg_alg;
      enable_reg     <= i_cfg_enable;
      // history and timeout held in range
      hist_len_reg   <= 6'(clamp32(32'(i_cfg_hist_len), frer_pkg::HIST_MIN, frer_pkg::HIST_MAX));
      timeout_reg    <= 12'(clamp32(32'(i_cfg_timeout_ms), frer_pkg::TMO_MIN, frer_pkg::TMO_MAX));
      untag_reg      <= i_cfg_accept_untagged_option;
      individual_reg <= i_cfg_individual;
      terminate_reg  <= i_cfg_terminate;
      lat_enable_reg <= i_cfg_lat_enable;
      err_diff_reg   <= 24'(clamp32(32'(i_cfg_err_diff), 0, frer_pkg::ERR_DIFF_MAX));
      lat_period_reg <= 27'(clamp32(32'(i_cfg_lat_period_ms), frer_pkg::LAT_MIN_MS,
                                    frer_pkg::LAT_MAX_MS));
      lat_reset_reg  <= 27'(clamp32(32'(i_cfg_lat_reset_ms), frer_pkg::LAT_MIN_MS,
                                    frer_pkg::LAT_MAX_MS));
      paths_reg      <= 4'(clamp32(32'(i_cfg_lat_paths), frer_pkg::PATHS_MIN, frer_pkg::PATHS_MAX));
      stream_map_reg <= i_cfg_stream_map;
      port_map_reg   <= i_cfg_port_map;
    end
  end

  // millisecond timebase
  logic [MS_W-1:0] ms_cnt_reg;
  wire             ms_tick = (ms_cnt_reg == MS_W'(CYC_PER_MS - 1));

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ms_cnt_reg <= '0;
    end else begin
      ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + MS_W'(1);
    end
  end

  // generator serves only the lowest mapped stream
  logic [$clog2(NS)-1:0] gen_stream;
  always_comb begin
    gen_stream = '0;
    for (int s = NS - 1; s >= 0; s--) begin
      if (stream_map_reg[s]) begin
        gen_stream = ($clog2(NS))'(s);
      end
    end
  end

  wire is_gen     = (o_mode == frer_pkg::MODE_GEN);
  wire member_hit = enable_reg && i_in_valid && stream_map_reg[i_in_stream];
  wire gen_hit    = member_hit && is_gen && (i_in_stream == gen_stream);
  wire rcvy_hit   = member_hit && !is_gen;

  // generator numbers wrap after the top value
  logic [15:0] gen_seq_reg;
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      gen_seq_reg <= 16'h0000;
    end else if (i_fn_reset) begin
      gen_seq_reg <= 16'h0000;
    end else if (gen_hit && |(port_map_reg & i_in_port_mask)) begin
      gen_seq_reg <= gen_seq_reg + 16'h0001;
    end
  end

  logic [NS*NP-1:0] ind_pass;
  logic [NP-1:0]    comp_pass;
  logic [NP-1:0]    eg_valid_next;
  logic [NP-1:0]    eg_tagged_next;
  logic [NP-1:0][15:0] eg_seq_next;

  for (genvar p = 0; p < NP; p++) begin : g_port
    wire           dest = rcvy_hit && port_map_reg[p] && i_in_port_mask[p];
    wire [NS-1:0]  ind_col;
    for (genvar s = 0; s < NS; s++) begin : g_stream
      assign ind_col[s] = ind_pass[s*NP+p];
      // per stream and port, ahead of compound
      frer_rcvy_fn #(.CNT_W(CNT_W)) u_ind (
        .i_ref_clk         (i_ref_clk),
        .i_reset           (i_reset),
        .i_alg             (alg_reg),
        .i_hist_len        (hist_len_reg),
        .i_timeout_ms      (timeout_reg),
        .i_accept_untagged (untag_reg),
        .i_ms_tick         (ms_tick),
        .i_fn_reset        (i_fn_reset),
        .i_stat_clear      (i_stat_clear),
        .i_frame_valid     (dest && individual_reg && (i_in_stream == ($clog2(NS))'(s))),
        .i_tagged          (i_in_tagged),
        .i_seq             (i_in_seq),
        .o_pass            (ind_pass[s*NP+p]),
        .o_passed          (),
        .o_discarded       (),
        .o_out_of_order    (),
        .o_rogue           (),
        .o_lost            (),
        .o_tagless         (),
        .o_resets          ()
      );
    end
    // compound uses the instance algorithm too
    frer_rcvy_fn #(.CNT_W(CNT_W)) u_comp (
      .i_ref_clk         (i_ref_clk),
      .i_reset           (i_reset),
      .i_alg             (alg_reg),
      .i_hist_len        (hist_len_reg),
      .i_timeout_ms      (timeout_reg),
      .i_accept_untagged (untag_reg),
      .i_ms_tick         (ms_tick),
      .i_fn_reset        (i_fn_reset),
      .i_stat_clear      (i_stat_clear),
      .i_frame_valid     (individual_reg ? |ind_col : dest),
      .i_tagged          (i_in_tagged),
      .i_seq             (i_in_seq),
      .o_pass            (comp_pass[p]),
      .o_passed          (o_cnt_passed[p]),
      .o_discarded       (o_cnt_discarded[p]),
      .o_out_of_order    (o_cnt_out_of_order[p]),
      .o_rogue           (o_cnt_rogue[p]),
      .o_lost            (o_cnt_lost[p]),
      .o_tagless         (o_cnt_tagless[p]),
      .o_resets          (o_cnt_resets[p])
    );
    assign eg_valid_next[p]  = is_gen ? (gen_hit && port_map_reg[p] && i_in_port_mask[p])
                                      : comp_pass[p];
    assign eg_tagged_next[p] = !terminate_reg;
    // passed untagged frames carry number zero
    assign eg_seq_next[p]    = is_gen ? gen_seq_reg : (i_in_tagged ? i_in_seq : 16'h0000);
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_eg_valid  <= '0;
      o_eg_tagged <= '0;
      o_eg_seq    <= '0;
    end else begin
      o_eg_valid  <= eg_valid_next;
      o_eg_tagged <= eg_tagged_next;
      o_eg_seq    <= eg_seq_next;
    end
  end

  // latent error detection over the compound counters of all ports
  logic [SUM_W-1:0] pass_sum;
  logic [SUM_W-1:0] disc_sum;
  always_comb begin
    pass_sum = '0;
    disc_sum = '0;
    for (int p = 0; p < NP; p++) begin
      pass_sum = pass_sum + SUM_W'(o_cnt_passed[p]);
      disc_sum = disc_sum + SUM_W'(o_cnt_discarded[p]);
    end
  end

  wire signed [63:0] lat_expr = signed'(64'(pass_sum) * 64'(paths_reg - 4'h1) - 64'(disc_sum));
  wire signed [63:0] lat_dev  = lat_expr - o_latent_baseline_difference;
  wire        [63:0] lat_abs  = lat_dev[63] ? 64'(-lat_dev) : 64'(lat_dev);

  logic [26:0] test_ms_reg;
  logic [26:0] rst_ms_reg;
  wire test_due  = ms_tick && ((test_ms_reg + 27'h0000001) >= lat_period_reg);
  wire reset_due = ms_tick && ((rst_ms_reg + 27'h0000001) >= lat_reset_reg);
  wire lat_set   = lat_enable_reg && test_due && (lat_abs > 64'(err_diff_reg));

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      test_ms_reg                  <= 27'h0000000;
      rst_ms_reg                   <= 27'h0000000;
      o_latent_baseline_difference <= 64'sh0;
      o_latent_error               <= 1'b0;
    end else begin
      if (ms_tick) begin
        test_ms_reg <= test_due ? 27'h0000000 : test_ms_reg + 27'h0000001;
        rst_ms_reg  <= reset_due ? 27'h0000000 : rst_ms_reg + 27'h0000001;
      end
      if (reset_due) begin
        o_latent_baseline_difference <= lat_expr;
      end
      // sticky flag, a new error beats the clear
      o_latent_error <= lat_set || (o_latent_error && !i_latent_clear);
    end
  end

  AST_LATENT_STICKY: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_latent_error && !i_latent_clear |=> o_latent_error)
    else $error("latent error flag dropped without clear");
  AST_LATENT_RAISE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    lat_enable_reg && test_due && (lat_abs > 64'(err_diff_reg)) |=> o_latent_error)
    else $error("latent error not raised on excess difference");
  AST_TERMINATE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    terminate_reg && !i_cfg_write |=> (o_eg_tagged == '0))
    else $error("tag kept on terminating instance");
  AST_UNTAG_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    rcvy_hit && !i_in_tagged && comp_pass[0] |=> o_eg_valid[0] && (o_eg_seq[0] == 16'h0000))
    else $error("untagged frame left with nonzero number");
endmodule

/* member_streams.sv */
// member stream source feeding the recovery instance
`timescale 1ns/1ps
module member_streams (
  // clock
  input  wire logic        i_ref_clk,
  // frames
  output logic             o_valid,
  output logic [2:0]       o_stream,
  output logic             o_tagged,
  output logic [15:0]      o_seq,
  output logic [7:0]       o_mask
);
  initial {o_valid, o_stream, o_tagged, o_seq, o_mask} = 29'h0000001;
  // numbers are taken modulo 16 bits
  task automatic send(input logic t, input logic [15:0] q);
    @(posedge i_ref_clk) #1;
    o_valid = 1'b1;
    o_stream = {2'h0, q[0]};
    o_tagged = t;
    o_seq = q;
    @(posedge i_ref_clk) #1;
    o_valid = 1'b0;
    // idle lines carry no frame, so never leave a stale number on them
    o_seq = ~o_seq;
  endtask
endmodule

/* frer_sequence_recovery_tb.sv */
// self-checking bench for the recovery instance
`timescale 1ns/1ps
module frer_sequence_recovery_tb;
  typedef struct packed {logic am; logic [15:0] seq; logic pas;} row_t;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic wr = 1'b0, fnr = 1'b0, opt = 1'b0, term = 1'b0, v, t;
  frer_pkg::mode_t mode = frer_pkg::MODE_RCVY;
  frer_pkg::alg_t alg = frer_pkg::ALG_VECTOR;
  logic [11:0] tmo = 12'h3e8;
  logic [2:0] s;
  logic [15:0] q;
  logic [7:0] m, egv, egt;
  logic [7:0][15:0] egs;
  logic [7:0][31:0] cp, cd, co, cr, ct, cl, cx;
  logic en = 1'b1, ind = 1'b0, len = 1'b0, sclr = 1'b0, lclr = 1'b0;
  logic [5:0] hl = 6'h02;
  logic [7:0] smap = 8'h03, pmap = 8'h01;
  logic [23:0] ed = 24'h000064;
  logic signed [63:0] lbd;
  logic [31:0] d0;
  frer_pkg::mode_t om;
  logic le;
  int fails = 0, checks_done = 0;
  row_t rows [13] = '{'{1, 16'h0005, 1}, '{1, 16'h0005, 0}, '{1, 16'h0006, 1},
    '{1, 16'h0009, 1}, '{1, 16'h0009, 0}, '{1, 16'h0005, 1}, '{0, 16'h000a, 1},
    '{0, 16'h000a, 0}, '{0, 16'h000c, 1}, '{0, 16'h000b, 1}, '{0, 16'h000b, 0},
    '{0, 16'h0064, 0}, '{0, 16'h000d, 1}};
  always #5 i_ref_clk = ~i_ref_clk;
  member_streams member_streams_inst (.i_ref_clk(i_ref_clk), .o_valid(v), .o_stream(s),
    .o_tagged(t), .o_seq(q), .o_mask(m));
  frer_sequence_recovery #(.CYC_PER_MS(10)) frer_sequence_recovery_inst (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_cfg_write(wr), .i_cfg_mode(mode),
    .i_cfg_enable(en), .i_cfg_alg(alg), .i_cfg_hist_len(hl), .i_cfg_timeout_ms(tmo),
    .i_cfg_accept_untagged_option(opt), .i_cfg_individual(ind), .i_cfg_terminate(term),
    .i_cfg_lat_enable(len), .i_cfg_err_diff(ed), .i_cfg_lat_period_ms(27'h00007d0),
    .i_cfg_lat_paths(4'h2), .i_cfg_lat_reset_ms(27'h0007530), .i_cfg_stream_map(smap),
    .i_cfg_port_map(pmap), .i_fn_reset(fnr), .i_stat_clear(sclr), .i_latent_clear(lclr),
    .i_in_valid(v), .i_in_stream(s), .i_in_tagged(t), .i_in_seq(q), .i_in_port_mask(m),
    .o_eg_valid(egv), .o_eg_tagged(egt), .o_eg_seq(egs), .o_mode(om), .o_latent_error(le),
    .o_latent_baseline_difference(lbd), .o_cnt_passed(cp), .o_cnt_discarded(cd),
    .o_cnt_out_of_order(co), .o_cnt_rogue(cr), .o_cnt_lost(cl), .o_cnt_tagless(ct),
    .o_cnt_resets(cx));
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // function reset rides with every write so each group starts in accept-any
  task automatic cfg(input logic a, input logic o, input logic tr, input logic [11:0] tm);
    @(posedge i_ref_clk) #1;
    alg = frer_pkg::alg_t'(a);
    opt = o;
    term = tr;
    tmo = tm;
    {wr, fnr} = 2'h3;
    @(posedge i_ref_clk) #1;
    {wr, fnr} = 2'h0;
  endtask
  task automatic fr(input logic tg, input logic [15:0] sq, input logic exp);
    member_streams_inst.send(tg, sq);
    chk("egress valid", {31'h0, egv[0]}, {31'h0, exp});
  endtask
  initial begin
    repeat (20) @(posedge i_ref_clk);
    #1 i_reset = 1'b0;
    chk("mode after reset", {31'h0, om}, 32'h0);
    chk("latent flag", {31'h0, le}, 32'h0);
    $display("reset test done");
    cfg(1'b1, 1'b0, 1'b0, 12'h3e8);
    chk("mode recovery", {31'h0, om}, 32'h1);
    for (int i = 0; i < 13; i++) begin
      if (i == 6) cfg(1'b0, 1'b0, 1'b0, 12'h3e8);
      fr(1'b1, rows[i].seq, rows[i].pas);
    end
    chk("passed", cp[0], 32'h8);
    chk("discarded", cd[0], 32'h5);
    chk("rogue", cr[0], 32'h1);
    chk("out of order", co[0], 32'h3);
    chk("lost", cl[0], 32'h1);
    chk("egress number", {16'h0, egs[0]}, 32'h000d);
    $display("table test done");
    cfg(1'b1, 1'b0, 1'b0, 12'h002);
    fr(1'b1, 16'h0007, 1'b1);
    fr(1'b1, 16'h0007, 1'b0);
    repeat (25) @(posedge i_ref_clk);
    fr(1'b1, 16'h0007, 1'b1);
    chk("timer resets", cx[0], 32'h1);
    $display("timer test done");
    cfg(1'b0, 1'b1, 1'b0, 12'h3e8);
    fr(1'b0, 16'h1234, 1'b1);
    chk("untagged number", {16'h0, egs[0]}, 32'h0);
    chk("tag kept", {31'h0, egt[0]}, 32'h1);
    cfg(1'b0, 1'b0, 1'b1, 12'h3e8);
    fr(1'b0, 16'h1235, 1'b0);
    chk("tagless", ct[0], 32'h2);
    fr(1'b1, 16'h0040, 1'b1);
    chk("tag stripped", {31'h0, egt[0]}, 32'h0);
    $display("untagged test done");
    mode = frer_pkg::MODE_GEN;
    cfg(1'b0, 1'b0, 1'b0, 12'h3e8);
    chk("mode generator", {31'h0, om}, 32'h0);
    fr(1'b1, 16'h0010, 1'b1);
    chk("first number", {16'h0, egs[0]}, 32'h0);
    fr(1'b1, 16'h0012, 1'b1);
    chk("second number", {16'h0, egs[0]}, 32'h1);
    fr(1'b1, 16'h0011, 1'b0);
    mode = frer_pkg::MODE_RCVY;
    en = 1'b0;
    cfg(1'b0, 1'b0, 1'b0, 12'h3e8);
    fr(1'b1, 16'h0030, 1'b0);
    $display("generator test done");
    en = 1'b1;
    ind = 1'b1;
    cfg(1'b0, 1'b0, 1'b0, 12'h3e8);
    fr(1'b1, 16'h0020, 1'b1);
    fr(1'b1, 16'h0021, 1'b1);
    d0 = cd[0];
    fr(1'b1, 16'h0021, 1'b0);
    chk("compound not presented", cd[0], d0);
    $display("individual test done");
    ind = 1'b0;
    len = 1'b1;
    ed = 24'h000000;
    cfg(1'b0, 1'b0, 1'b0, 12'h3e8);
    @(posedge i_ref_clk) #1 sclr = 1'b1;
    @(posedge i_ref_clk) #1 sclr = 1'b0;
    chk("cleared passed", cp[0], 32'h0);
    fr(1'b1, 16'h0050, 1'b1);
    // one test period is 20000 cycles here, so the bound leaves some slack
    for (int k = 0; k < 25000 && !le; k++) @(posedge i_ref_clk) #1;
    chk("latent flag raised", {31'h0, le}, 32'h1);
    @(posedge i_ref_clk) #1 lclr = 1'b1;
    @(posedge i_ref_clk) #1 lclr = 1'b0;
    chk("latent flag cleared", {31'h0, le}, 32'h0);
    $display("latent test done");
    @(posedge i_ref_clk) #1 i_reset = 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1 i_reset = 1'b0;
    chk("mode after second reset", {31'h0, om}, 32'h0);
    chk("passed after reset", cp[0], 32'h0);
    chk("baseline after reset", lbd[31:0], 32'h0);
    $display("second reset test done");
    end_of_test();
  end
endmodule
